// ---- design/ledio_target.sv ----
// two-wire serial target loading an eight-channel output register
// Functional notes
// (RQ1) write 11H loads shift register only
// (RQ2) write 11H acknowledges address, subaddress, data
// (RQ3) 11H write then read returns shift register
// (RQ4) 22H copies shift to output in ack
// (RQ5) 44H loads data then copies to output
// (RQ6) 44H with read bit does nothing
// (RQ7) undefined subaddress: only address acknowledged
// (RQ8) start: data falls while clock high
// (RQ9) stop: data rises while clock high
// (RQ10) data changes only while clock low
// (RQ11) idle bus: controller leaves lines high
// (RQ12) controller clocks; target only pulls low
// (RQ13) match group and strap, then expect subaddress
// (RQ14) transaction ends at stop or data byte
// (RQ15) output register bits drive the outputs
// (RQ16) reset clears shift and output registers
// (RQ17) bytes msb first, one ack clock each
`timescale 1ns/10ps
`default_nettype none
`include "ledio_map.svh"

module ledio_target
    import ledio_pkg::*;
#(
    // arbitrary group identifier value
    parameter logic [3:0] GROUP_ID = 4'ha
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic [2:0] addr_strap_in,
    output logic      [7:0] drive_out
);

    logic [2:0]   scl_sync_ff;
    logic [2:0]   sda_sync_ff;
    logic [2:0]   strap_s1_ff;
    logic [2:0]   strap_s2_ff;
    ledio_state_t state_ff;
    logic [3:0]   cnt_ff;
    logic [7:0]   rx_ff;
    logic [7:0]   tx_ff;
    logic [7:0]   sub_ff;
    logic [7:0]   shift_ff;
    logic [7:0]   out_ff;
    logic         rw_ff;
    logic         armed_ff;
    logic         oe_ff;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_det;
    logic         stop_det;
    logic         byte_end;
    logic         sub_ok;

    function automatic logic sub_valid(input logic [7:0] s,
                                       input logic       rd);
        sub_valid = (s == `LEDIO_SUB_WRITE) || (s == `LEDIO_SUB_LOAD)
                    || ((s == `LEDIO_SUB_XFER) && !rd);
    endfunction

    function automatic logic addr_match(input logic [7:0] a,
                                        input logic [2:0] p);
        addr_match = (a[`LEDIO_GRP_MSB:`LEDIO_GRP_LSB] == GROUP_ID)
                     && (a[`LEDIO_ADR_MSB:`LEDIO_ADR_LSB] == p);
    endfunction

    // pins pass two stages; stage three only feeds edge detection
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            strap_s1_ff <= 3'h0;
            strap_s2_ff <= 3'h0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
            strap_s1_ff <= addr_strap_in;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    assign scl_rise  = scl_sync_ff[1] && !scl_sync_ff[2];
    assign scl_fall  = !scl_sync_ff[1] && scl_sync_ff[2];
    // (RQ8) start while high
    assign start_det = scl_sync_ff[1] && scl_sync_ff[2]
                       && !sda_sync_ff[1] && sda_sync_ff[2];
    // (RQ9) stop while high
    assign stop_det  = scl_sync_ff[1] && scl_sync_ff[2]
                       && sda_sync_ff[1] && !sda_sync_ff[2];
    assign byte_end  = scl_fall && (cnt_ff == `LEDIO_BYTE_BITS);
    assign sub_ok    = sub_valid(rx_ff, rw_ff);

    // protocol sequencer; start and stop override any bit phase
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_ff <= LEDIO_IDLE;
        end else if (start_det) begin
            state_ff <= LEDIO_ADDR;
        end else if (stop_det) begin
            state_ff <= LEDIO_IDLE;
        end else if (scl_fall) begin
            case (state_ff)
                LEDIO_ADDR: begin
                    // (RQ13) group and strap match
                    if (byte_end) begin
                        state_ff <= addr_match(rx_ff, strap_s2_ff)
                                    ? LEDIO_A_ACK : LEDIO_IGNORE;
                    end
                end
                LEDIO_A_ACK: begin
                    // (RQ3) armed read goes straight to data
                    state_ff <= (rw_ff && armed_ff) ? LEDIO_TX : LEDIO_SUB;
                end
                LEDIO_SUB: begin
                    // (RQ7) undefined subaddress is not acknowledged
                    if (byte_end) begin
                        state_ff <= sub_ok ? LEDIO_S_ACK : LEDIO_IGNORE;
                    end
                end
                LEDIO_S_ACK: begin
                    if (sub_ff == `LEDIO_SUB_WRITE && rw_ff) begin
                        state_ff <= LEDIO_TX;
                    end else if (sub_ff == `LEDIO_SUB_XFER || rw_ff) begin
                        // (RQ6) read-direction load ignores its data
                        state_ff <= LEDIO_IGNORE;
                    end else begin
                        state_ff <= LEDIO_DATA;
                    end
                end
                LEDIO_DATA: begin
                    if (byte_end) begin
                        state_ff <= LEDIO_D_ACK;
                    end
                end
                // (RQ14) finished after the data byte
                LEDIO_D_ACK: state_ff <= LEDIO_IGNORE;
                LEDIO_TX: begin
                    if (cnt_ff == 4'h7) begin
                        state_ff <= LEDIO_IGNORE;
                    end
                end
                default: state_ff <= state_ff;
            endcase
        end
    end

    // (RQ17) msb first, counter steps once per data bit clock and clears for the ack clock
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_ff <= 4'h0;
            rx_ff  <= 8'h00;
        end else if (start_det) begin
            cnt_ff <= 4'h0;
        end else if (scl_rise && (state_ff == LEDIO_ADDR
                                  || state_ff == LEDIO_SUB
                                  || state_ff == LEDIO_DATA)) begin
            cnt_ff <= cnt_ff + 4'h1;
            rx_ff  <= {rx_ff[6:0], sda_sync_ff[1]};
        end else if (scl_fall && state_ff == LEDIO_TX) begin
            cnt_ff <= cnt_ff + 4'h1;
        end else if (scl_fall && (cnt_ff == `LEDIO_BYTE_BITS
                                  || state_ff == LEDIO_A_ACK
                                  || state_ff == LEDIO_S_ACK)) begin
            cnt_ff <= 4'h0;
        end
    end

    // transfer attributes; the read arm survives only a repeated start
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rw_ff    <= 1'b0;
            sub_ff   <= 8'h00;
            armed_ff <= 1'b0;
        end else if (stop_det) begin
            armed_ff <= 1'b0;
        end else if (byte_end && state_ff == LEDIO_ADDR) begin
            rw_ff <= rx_ff[`LEDIO_RW_BIT];
        end else if (byte_end && state_ff == LEDIO_SUB) begin
            sub_ff   <= rx_ff;
            armed_ff <= (rx_ff == `LEDIO_SUB_WRITE) && !rw_ff;
        end
    end

    // (RQ16) registers clear to all outputs off
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_ff <= `LEDIO_REG_RESET;
            out_ff   <= `LEDIO_REG_RESET;
        end else if (byte_end && state_ff == LEDIO_DATA) begin
            // (RQ1) load shift register
            shift_ff <= rx_ff;
            // (RQ5) copy during data ack
            if (sub_ff == `LEDIO_SUB_LOAD) begin
                out_ff <= rx_ff;
            end
        end else if (byte_end && state_ff == LEDIO_SUB
                     && rx_ff == `LEDIO_SUB_XFER && !rw_ff) begin
            // (RQ4) copy during subaddress ack
            out_ff <= shift_ff;
        end
    end

    // (RQ10) line moves after a clock fall, or is released at start and stop
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (start_det || stop_det) begin
            oe_ff <= 1'b0;
        end else if (scl_fall) begin
            case (state_ff)
                // (RQ2) ack each accepted byte
                LEDIO_ADDR: oe_ff <= byte_end
                                     && addr_match(rx_ff, strap_s2_ff);
                LEDIO_DATA: oe_ff <= byte_end;
                LEDIO_SUB: oe_ff <= byte_end && sub_ok;
                LEDIO_A_ACK,
                LEDIO_S_ACK: begin
                    tx_ff <= shift_ff;
                    oe_ff <= ((rw_ff && armed_ff && state_ff == LEDIO_A_ACK)
                              || (rw_ff && state_ff == LEDIO_S_ACK
                                  && sub_ff == `LEDIO_SUB_WRITE))
                             && !shift_ff[7];
                end
                LEDIO_TX: begin
                    tx_ff <= {tx_ff[6:0], 1'b0};
                    oe_ff <= (cnt_ff != 4'h7) && !tx_ff[6];
                end
                default: oe_ff <= 1'b0;
            endcase
        end
    end

    // (RQ12) open drain: data output held low, only enable moves
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // (RQ15) output register drives the channels directly
    assign sda_oe_out = oe_ff;
    assign drive_out  = out_ff;

    a_start_to_addr: assert property ( // (RQ8)
        @(posedge clk_in) disable iff (sys_rst_in)
        start_det |=> state_ff == LEDIO_ADDR)
        else $error("start not followed by address phase");
    a_stop_to_idle: assert property ( // (RQ9)
        @(posedge clk_in) disable iff (sys_rst_in)
        stop_det && !start_det |=> state_ff == LEDIO_IDLE && !sda_oe_out)
        else $error("stop did not return to idle");
    a_sda_clock_low: assert property ( // (RQ10)
        @(posedge clk_in) disable iff (sys_rst_in)
        $changed(sda_oe_out) && !$past(start_det) && !$past(stop_det)
        |-> !scl_sync_ff[2])
        else $error("data line moved while clock high");
    a_addr_ack_match: assert property ( // (RQ13)
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_ff == LEDIO_A_ACK)
        |-> sda_oe_out && addr_match(rx_ff, strap_s2_ff))
        else $error("address ack without match");
    a_undef_no_ack: assert property ( // (RQ7)
        @(posedge clk_in) disable iff (sys_rst_in)
        state_ff == LEDIO_IGNORE && $past(state_ff) == LEDIO_SUB
        |-> !sda_oe_out)
        else $error("undefined subaddress acknowledged");
    a_xfer_copy: assert property ( // (RQ4)
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_ff == LEDIO_S_ACK) && sub_ff == `LEDIO_SUB_XFER
        |-> out_ff == shift_ff && sda_oe_out)
        else $error("transfer command did not copy");
    a_data_ack_load: assert property ( // (RQ2)
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_ff == LEDIO_D_ACK) |-> sda_oe_out && !rw_ff
        && shift_ff == $past(rx_ff))
        else $error("data byte not loaded and acknowledged");
    a_write_keeps_out: assert property ( // (RQ1)
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_ff == LEDIO_D_ACK) && sub_ff == `LEDIO_SUB_WRITE
        |-> $stable(out_ff))
        else $error("plain write changed outputs");
    a_load_copies: assert property ( // (RQ5)
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(state_ff == LEDIO_D_ACK) && sub_ff == `LEDIO_SUB_LOAD
        |-> out_ff == shift_ff)
        else $error("load command did not reach outputs");

endmodule

`default_nettype wire

// ---- design/ledio_map.svh ----
// register offsets are absent; command codes, field positions, byte length and reset value only
`ifndef LEDIO_MAP_SVH
`define LEDIO_MAP_SVH

`define LEDIO_SUB_WRITE  8'h11
`define LEDIO_SUB_XFER   8'h22
`define LEDIO_SUB_LOAD   8'h44
`define LEDIO_BYTE_BITS  4'h8
`define LEDIO_GRP_MSB    7
`define LEDIO_GRP_LSB    4
`define LEDIO_ADR_MSB    3
`define LEDIO_ADR_LSB    1
`define LEDIO_RW_BIT     0
`define LEDIO_REG_RESET  8'h00

`endif

// ---- design/ledio_pkg.sv ----
// types shared by the serial command target
package ledio_pkg;
    typedef enum logic [3:0] {
        LEDIO_IDLE,
        LEDIO_ADDR,
        LEDIO_A_ACK,
        LEDIO_SUB,
        LEDIO_S_ACK,
        LEDIO_DATA,
        LEDIO_D_ACK,
        LEDIO_TX,
        LEDIO_IGNORE
    } ledio_state_t;
endpackage

// ---- bench/ledio_bus_ctl.sv ----
// bus controller model: sources the serial clock, pulls data low only
`timescale 1ns/10ps
`default_nettype none

module ledio_bus_ctl (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // data moves only while our clock is low (5 of 8 cycles)
    task automatic bit_cycle(input logic b, output logic seen);
        sda_low_out = ~b;
        wait_clk(2);
        scl_out = 1'b1;
        wait_clk(2);
        seen = sda_in;
        wait_clk(1);
        scl_out = 1'b0;
        wait_clk(3);
    endtask

    // data falls while clock high, repeated start included
    task automatic start();
        if (!scl_out) begin
            sda_low_out = 1'b0;
            wait_clk(2);
            scl_out = 1'b1;
            wait_clk(3);
        end
        sda_low_out = 1'b1;
        wait_clk(4);
        scl_out = 1'b0;
        wait_clk(3);
    endtask

    task automatic stop();
        sda_low_out = 1'b1;
        wait_clk(2);
        scl_out = 1'b1;
        wait_clk(3);
        sda_low_out = 1'b0;
        wait_clk(4);
    endtask

    // msb first, then one acknowledge clock
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(v[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // controller answers the read byte with a release
    task automatic get_byte(output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            v[i] = s;
        end
        bit_cycle(1'b1, s);
    endtask
endmodule

`default_nettype wire

// ---- bench/ledio_target_test.sv ----
// self-checking bench for the serial command target
`timescale 1ns/10ps
`default_nettype none

module ledio_target_test;
    // group value is arbitrary
    localparam logic [3:0] GRP   = 4'ha;
    localparam logic [2:0] STRAP = 3'h5;
    logic       clk_in;
    logic       sys_rst_in;
    logic       scl;
    logic       sda_low;
    logic       sda_out;
    logic       sda_oe_out;
    logic [7:0] drive_out;
    logic [2:0] strap;
    wire logic  sda_wire;
    int         err_count = 0;
    int         checks = 0;
    int         cycles = 0;

    // pull-up wins unless some party pulls low
    assign sda_wire = ~(sda_low | sda_oe_out);

    ledio_target #(.GROUP_ID(GRP)) uut (.clk_in(clk_in),
        .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .addr_strap_in(strap), .drive_out(drive_out));
    ledio_bus_ctl ctl (.clk_in(clk_in), .sda_in(sda_wire),
        .scl_out(scl), .sda_low_out(sda_low));

    task automatic stop_test();
        $display("counts: %0d checks, %0d mismatches", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_ack(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", n, e, g);
        end
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    function automatic logic [7:0] adr(input logic rw);
        return {GRP, STRAP, rw};
    endfunction

    task automatic xfer(input logic [7:0] a, s, d, input logic [2:0] e);
        logic k0, k1, k2;
        ctl.start();
        ctl.put_byte(a, k0);
        ctl.put_byte(s, k1);
        ctl.put_byte(d, k2);
        ctl.stop();
        chk_ack("address ack", e[2], k0);
        chk_ack("subaddress ack", e[1], k1);
        chk_ack("data ack", e[0], k2);
    endtask

    task automatic t_write_read();
        logic       k;
        logic [7:0] v;
        xfer(adr(0), 8'h11, 8'ha5, 3'b111);
        chk_byte("outputs", 8'h00, drive_out);
        ctl.start();
        ctl.put_byte(adr(0), k);
        ctl.put_byte(8'h11, k);
        ctl.start();
        ctl.put_byte(adr(1), k);
        chk_ack("read address ack", 1'b1, k);
        ctl.get_byte(v);
        ctl.stop();
        chk_byte("read byte", 8'ha5, v);
        // read-direction address with 11H also returns the shift register
        ctl.start();
        ctl.put_byte(adr(1), k);
        ctl.put_byte(8'h11, k);
        chk_ack("direct read subaddress ack", 1'b1, k);
        ctl.get_byte(v);
        ctl.stop();
        chk_byte("direct read byte", 8'ha5, v);
        $display("done: write and read");
    endtask

    task automatic t_commands();
        xfer(adr(0), 8'h22, 8'h5a, 3'b110);
        chk_byte("outputs", 8'ha5, drive_out);
        xfer(adr(0), 8'h44, 8'h3c, 3'b111);
        chk_byte("outputs", 8'h3c, drive_out);
        xfer(adr(1), 8'h44, 8'h0f, 3'b110);
        xfer(adr(0), 8'h22, 8'h00, 3'b110);
        chk_byte("outputs", 8'h3c, drive_out);
        $display("done: commands");
    endtask

    task automatic t_refused();
        logic [7:0] subs [4] = '{8'h00, 8'h33, 8'h12, 8'hff};
        logic       k;
        foreach (subs[i]) xfer(adr(0), subs[i], 8'h77, 3'b100);
        xfer({GRP, STRAP ^ 3'h1, 1'b0}, 8'h44, 8'h81, 3'b000);
        xfer({GRP ^ 4'h8, STRAP, 1'b0}, 8'h44, 8'h81, 3'b000);
        xfer(adr(1), 8'h22, 8'h77, 3'b100);
        // the strap pins, not a fixed value, set the address
        strap = STRAP ^ 3'h3;
        xfer({GRP, STRAP ^ 3'h3, 1'b0}, 8'h11, 8'h55, 3'b111);
        xfer(adr(0), 8'h11, 8'h55, 3'b000);
        strap = STRAP;
        chk_byte("outputs", 8'h3c, drive_out);
        ctl.start();
        ctl.put_byte(adr(0), k);
        ctl.put_byte(8'h44, k);
        ctl.put_byte(8'h96, k);
        ctl.put_byte(8'h42, k);
        ctl.stop();
        chk_ack("extra byte ack", 1'b0, k);
        chk_byte("outputs", 8'h96, drive_out);
        $display("done: refused traffic");
    endtask

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // sampled mid-cycle, clear of the edge that launches the outputs
    always @(negedge clk_in) begin
        cycles++;
        // the data pin is only ever pulled low
        if (sda_oe_out === 1'b1 && sda_out !== 1'b0) begin
            err_count++;
            $display("unexpected sda_out: expected 0, seen %b", sda_out);
        end
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        strap      = STRAP;
        sys_rst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        ctl.wait_clk(4);
        chk_byte("outputs after reset", 8'h00, drive_out);
        t_write_read();
        t_commands();
        t_refused();
        stop_test();
    end
endmodule

`default_nettype wire
